/* File: include/lps_params.svh */
// constants for the line protection switch controller
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH
`define LPS_LOCK_COUNT_DEF   8'h04
`define LPS_WATCH_MIN_DEF    6'h0A
`define LPS_HOLD_HOUR_DEF    6'h18
`define LPS_SEC_PER_MIN      6'h3C
`define LPS_MIN_PER_HOUR     6'h3C
`define LPS_TICK_PERIOD_S    1
`endif

/* File: include/lps_pkg.sv */
// types for the line protection switch controller
package lps_pkg;
    typedef enum logic [2:0] {
        LPS_WIN_NONE,
        LPS_WIN_UNEQ,
        LPS_WIN_LOCK,
        LPS_WIN_FORCE,
        LPS_WIN_FAIL,
        LPS_WIN_DEGRADE,
        LPS_WIN_MANUAL
    } lps_win_t;

    typedef struct packed {
        logic       redundant_unit_absent;
        logic       work_line_fail;
        logic       protect_line_fail;
        logic       work_line_degrade;
        logic       protect_line_degrade;
    } lps_alarm_t;

    typedef struct packed {
        logic       maint_forced;
        logic       prot_fail_high;
        logic       degrade_included;
        logic       lockin_used;
        logic [7:0] lock_count;
        logic [5:0] watch_min;
        logic [5:0] hold_hour;
    } lps_cfg_t;

    typedef struct packed {
        logic       forced_switch_request;
        logic       manual_switch_request;
        logic       target_protect;
    } lps_cmd_t;
endpackage : lps_pkg

/* File: hw/lps_tick_div.sv */
// divider turning a slow tick into a pulse every DIV ticks
`timescale 1ns/1ps
module lps_tick_div
    import lps_pkg::*;
#(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         CLK,
    input  wire logic         RESETN,
    // control
    input  wire logic         CLEAR,
    input  wire logic         TICK_IN,
    input  wire logic [W-1:0] DIV,
    // output
    output logic              TICK_OUT
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } lps_div_st_t;

    lps_div_st_t st;
    lps_div_st_t next_st;

    always_comb begin
        next_st       = st;
        next_st.pulse = 1'b0;
        if (CLEAR) begin
            next_st.cnt = '0;
        end else if (TICK_IN) begin
            if (st.cnt >= DIV - W'(1)) begin
                next_st.cnt   = '0;
                next_st.pulse = 1'b1;
            end else begin
                next_st.cnt = st.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign TICK_OUT = st.pulse;
endmodule : lps_tick_div

/* File: hw/lps_ctrl.sv */
// receive-side line protection switch controller
`timescale 1ns/1ps
`include "lps_params.svh"

// Summary of operation
// - switch only local receive path, one direction
// - alarms or remote command start a switchover
// - low priority: redundant_unit_absent, lock, force, fail, degrade, manual
// - high priority: protect fail above forced switch
// - lock-in ignored when lock-in not used
// - degrade ignored when degrade excluded
// - manual mode: manual blocked on alarmed target
// - forced mode: operator choice kept despite alarm
// - protect fail high keeps main line online
// - degrade at threshold requests switchover
// - count threshold 1 to 255, default 4
// - watch interval 1 to 60 min, default 10
// - hold time 1 to 48 hours, default 24
// - too many switches in interval enters lock-in
// - lock-in suppresses switching for hold time, except redundant_unit_absent forcing working line
// - hold expiry or lock-in setting change ends lock-in
// - lock-in state readable as status
module lps_ctrl
    import lps_pkg::*;
(
    // clock and reset
    input  wire logic  CLK,
    input  wire logic  RESETN,
    // time base
    input  wire logic  SEC_TICK,
    // line alarm detectors
    input  lps_alarm_t ALARM,
    // craft terminal commands
    input  lps_cmd_t   CMD,
    // provisioning
    input  lps_cfg_t   CFG,
    // status
    output logic       SELECT_PROTECT,
    output logic       LOCKIN_ACTIVE,
    output lps_win_t   WINNER
);
    typedef struct packed {
        logic       sel;
        logic       lockin;
        logic [8:0] sw_count;
        logic [5:0] watch_min;
        logic [5:0] hold_hour;
        lps_cfg_t   cfg_last;
        lps_win_t   winner;
    } lps_st_t;

    lps_st_t  st;
    lps_st_t  next_st;
    logic     min_tick;
    logic     hour_tick;
    logic     cfg_changed;
    logic     lock_clr;
    logic     want_sel;
    lps_win_t win;
    logic     hold_prot_fail;
    logic     fire;

    ////////////////////////////////////////////////////////////////////////////
    // time base

    lps_tick_div #(.W(6)) u_min_div (
        .CLK      (CLK),
        .RESETN   (RESETN),
        .CLEAR    (1'b0),
        .TICK_IN  (SEC_TICK),
        .DIV      (`LPS_SEC_PER_MIN),
        .TICK_OUT (min_tick)
    );

    lps_tick_div #(.W(6)) u_hour_div (
        .CLK      (CLK),
        .RESETN   (RESETN),
        .CLEAR    (lock_clr),
        .TICK_IN  (min_tick),
        .DIV      (`LPS_MIN_PER_HOUR),
        .TICK_OUT (hour_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // arbitration

    assign cfg_changed = (CFG.lockin_used != st.cfg_last.lockin_used)
                       | (CFG.lock_count != st.cfg_last.lock_count)
                       | (CFG.watch_min != st.cfg_last.watch_min)
                       | (CFG.hold_hour != st.cfg_last.hold_hour);
    assign lock_clr    = cfg_changed | !st.lockin;

    always_comb begin
        win            = LPS_WIN_NONE;
        want_sel       = st.sel;
        hold_prot_fail = 1'b0;
        if (ALARM.redundant_unit_absent) begin
            win      = LPS_WIN_UNEQ;
            want_sel = 1'b0;
        end else if (CFG.lockin_used && st.lockin) begin
            win = LPS_WIN_LOCK;
        end else if (CFG.prot_fail_high && ALARM.protect_line_fail) begin
            win            = LPS_WIN_FAIL;
            want_sel       = 1'b0;
            hold_prot_fail = 1'b1;
        end else if (CFG.maint_forced && CMD.forced_switch_request) begin
            win      = LPS_WIN_FORCE;
            want_sel = CMD.target_protect;
        end else if (ALARM.work_line_fail != ALARM.protect_line_fail) begin
            win      = LPS_WIN_FAIL;
            want_sel = ALARM.work_line_fail;
        end else if (CFG.degrade_included
                     && (ALARM.work_line_degrade != ALARM.protect_line_degrade)) begin
            win      = LPS_WIN_DEGRADE;
            want_sel = ALARM.work_line_degrade;
        end else if (CMD.manual_switch_request
                     && !(CMD.target_protect ? ALARM.protect_line_fail
                                             : ALARM.work_line_fail)) begin
            win      = LPS_WIN_MANUAL;
            want_sel = CMD.target_protect;
        end
    end

    // only a winner other than lock whose wanted select differs from the current one moves select
    assign fire = (win != LPS_WIN_NONE) && (win != LPS_WIN_LOCK) && (want_sel != st.sel);

    ////////////////////////////////////////////////////////////////////////////
    // state update

    always_comb begin
        next_st          = st;
        next_st.cfg_last = CFG;
        next_st.winner   = win;
        if (fire) begin
            next_st.sel = want_sel;
        end
        if (st.lockin) begin
            if (hour_tick) begin
                next_st.hold_hour = st.hold_hour + 6'h01;
            end
            if (cfg_changed || !CFG.lockin_used
                || (hour_tick && (st.hold_hour + 6'h01 >= CFG.hold_hour))) begin
                next_st.lockin    = 1'b0;
                next_st.hold_hour = '0;
                next_st.sw_count  = '0;
                next_st.watch_min = '0;
            end
        end else begin
            if (min_tick) begin
                if (st.watch_min + 6'h01 >= CFG.watch_min) begin
                    next_st.watch_min = '0;
                    next_st.sw_count  = '0;
                end else begin
                    next_st.watch_min = st.watch_min + 6'h01;
                end
            end
            if (fire) begin
                next_st.sw_count = next_st.sw_count + 9'h001;
            end
            if (CFG.lockin_used && !cfg_changed
                && (next_st.sw_count > {1'b0, CFG.lock_count})) begin
                next_st.lockin    = 1'b1;
                next_st.hold_hour = '0;
            end
            if (cfg_changed) begin
                next_st.sw_count  = '0;
                next_st.watch_min = '0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st                    <= '0;
            st.cfg_last.lockin_used <= 1'b1;
            st.cfg_last.lock_count  <= `LPS_LOCK_COUNT_DEF;
            st.cfg_last.watch_min   <= `LPS_WATCH_MIN_DEF;
            st.cfg_last.hold_hour   <= `LPS_HOLD_HOUR_DEF;
        end else begin
            st <= next_st;
        end
    end

    assign LOCKIN_ACTIVE  = st.lockin;
    assign SELECT_PROTECT = st.sel;
    assign WINNER         = st.winner;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_PROT_FAIL_HOLDS: assert property (@(posedge CLK) disable iff (!RESETN)
        (hold_prot_fail && !ALARM.redundant_unit_absent) |=> !SELECT_PROTECT)
        else $error("protect fail did not keep main line");
    AST_UNEQ_WORK: assert property (@(posedge CLK) disable iff (!RESETN)
        ALARM.redundant_unit_absent |=> !SELECT_PROTECT)
        else $error("unequipped did not select working");
    AST_LOCK_FREEZE: assert property (@(posedge CLK) disable iff (!RESETN)
        (st.lockin && CFG.lockin_used && !ALARM.redundant_unit_absent)
        |=> $stable(SELECT_PROTECT))
        else $error("select moved during lock-in");
    // select moves with a real winner
    AST_SEL_CAUSE: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(SELECT_PROTECT) |-> (WINNER != LPS_WIN_NONE) && (WINNER != LPS_WIN_LOCK))
        else $error("select changed without a winner");
    AST_RELEASE: assert property (@(posedge CLK) disable iff (!RESETN)
        (st.lockin && !CFG.lockin_used) |=> !LOCKIN_ACTIVE)
        else $error("lock-in not released when unused");
    AST_MANUAL_BLOCK: assert property (@(posedge CLK) disable iff (!RESETN)
        (win == LPS_WIN_MANUAL) |-> !(CMD.target_protect ? ALARM.protect_line_fail
                                                          : ALARM.work_line_fail))
        else $error("manual won onto alarmed line");
    AST_DEGRADE_EXCL: assert property (@(posedge CLK) disable iff (!RESETN)
        !CFG.degrade_included |-> (win != LPS_WIN_DEGRADE))
        else $error("degrade used while excluded");
    AST_FAIL_SWITCH: assert property (@(posedge CLK) disable iff (!RESETN)
        (win == LPS_WIN_FAIL && ALARM.work_line_fail && !ALARM.protect_line_fail)
        |=> SELECT_PROTECT)
        else $error("work fail did not select protection");

    ////////////////////////////////////////////////////////////////////////////
    // lock-in, arbitration and time base checks

    // lock-in low, then high one edge later
    sequence seq_lock_entry;
        !LOCKIN_ACTIVE ##1 LOCKIN_ACTIVE;
    endsequence

    // a lock-in setting edited while locked
    sequence seq_cfg_edit;
        st.lockin && cfg_changed;
    endsequence

    AST_ENTRY_USED: assert property (@(posedge CLK) disable iff (!RESETN)
        seq_lock_entry |-> $past(CFG.lockin_used))
        else $error("lock-in entered while not used");
    AST_ENTRY_ON_SWITCH: assert property (@(posedge CLK) disable iff (!RESETN)
        seq_lock_entry |-> $changed(SELECT_PROTECT))
        else $error("lock-in entered without a switchover");
    AST_EDIT_RELEASE: assert property (@(posedge CLK) disable iff (!RESETN)
        seq_cfg_edit |=> !LOCKIN_ACTIVE)
        else $error("lock-in kept after a setting change");
    AST_LOCK_WINNER: assert property (@(posedge CLK) disable iff (!RESETN)
        (LOCKIN_ACTIVE && CFG.lockin_used && !ALARM.redundant_unit_absent)
        |=> (WINNER == LPS_WIN_LOCK))
        else $error("locked arbitration not reported");

    AST_PROT_HIGH: assert property (@(posedge CLK) disable iff (!RESETN)
        (CFG.prot_fail_high && ALARM.protect_line_fail && CFG.maint_forced
         && CMD.forced_switch_request && !ALARM.redundant_unit_absent && !LOCKIN_ACTIVE)
        |=> (WINNER == LPS_WIN_FAIL))
        else $error("forced switch beat protect fail");
    AST_FORCE_TARGET: assert property (@(posedge CLK) disable iff (!RESETN)
        (win == LPS_WIN_FORCE) |=> (SELECT_PROTECT == $past(CMD.target_protect)))
        else $error("forced selection not followed");
    AST_DEGRADE_SWITCH: assert property (@(posedge CLK) disable iff (!RESETN)
        (win == LPS_WIN_DEGRADE) |=> (SELECT_PROTECT == $past(ALARM.work_line_degrade)))
        else $error("degrade did not move to clean line");

    AST_HOLD_IDLE: assert property (@(posedge CLK) disable iff (!RESETN)
        !LOCKIN_ACTIVE |-> (st.hold_hour == '0))
        else $error("hold counter ran outside lock-in");
    AST_HOUR_FROM_MIN: assert property (@(posedge CLK) disable iff (!RESETN)
        hour_tick |-> $past(min_tick))
        else $error("hour pulse without minute pulse");
    AST_MIN_FROM_SEC: assert property (@(posedge CLK) disable iff (!RESETN)
        min_tick |-> $past(SEC_TICK))
        else $error("minute pulse without second tick");
endmodule : lps_ctrl

/* File: verification/lps_far_model.sv */
// far side model: alarm detectors, craft terminal and time base
`timescale 1ns/1ps
module lps_far_model
    import lps_pkg::*;
(
    // clock
    input  wire logic  CLK,
    // requested state
    input  lps_alarm_t WANT_ALARM,
    input  lps_cmd_t   WANT_CMD,
    input  lps_cfg_t   WANT_CFG,
    input  wire logic  WANT_TICK,
    // toward the controller
    output lps_alarm_t ALARM,
    output lps_cmd_t   CMD,
    output lps_cfg_t   CFG,
    output logic       SEC_TICK
);
    always @(negedge CLK) begin
        ALARM    <= WANT_ALARM;
        CMD      <= WANT_CMD;
        CFG      <= WANT_CFG;
        SEC_TICK <= WANT_TICK;
    end
endmodule : lps_far_model

/* File: verification/tb.sv */
// self-checking bench for the line protection switch controller
`timescale 1ns/1ps
module tb
    import lps_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    lps_alarm_t  want_alarm = '0;
    lps_cmd_t    want_cmd = '0;
    lps_cfg_t    want_cfg = '0;
    logic        want_tick = 1'b0;
    lps_alarm_t  alarm;
    lps_cmd_t    cmd;
    lps_cfg_t    cfg;
    logic        sec_tick;
    logic        sel;
    logic        lock;
    lps_win_t    win;
    lps_alarm_t  pf;
    lps_alarm_t  wf;
    lps_alarm_t  a;
    lps_cmd_t    c;
    lps_cfg_t    g;
    logic [15:0] lfsr = 16'h0015;
    logic [4:0]  exp;
    logic        last_sel = 1'b0;
    int          n_fail = 0;
    int          check_count = 0;
    int          cnt;

    always #2 clk = ~clk;

    lps_far_model far (.CLK(clk), .WANT_ALARM(want_alarm), .WANT_CMD(want_cmd),
        .WANT_CFG(want_cfg), .WANT_TICK(want_tick), .ALARM(alarm), .CMD(cmd),
        .CFG(cfg), .SEC_TICK(sec_tick));
    lps_ctrl dut (.CLK(clk), .RESETN(resetn), .SEC_TICK(sec_tick), .ALARM(alarm),
        .CMD(cmd), .CFG(cfg), .SELECT_PROTECT(sel), .LOCKIN_ACTIVE(lock), .WINNER(win));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // {valid, winner, select}; valid low where nothing wins and select holds
    function automatic logic [4:0] expect_arb(lps_alarm_t x, lps_cmd_t k, lps_cfg_t s);
        if (x.redundant_unit_absent) return {1'b1, LPS_WIN_UNEQ, 1'b0};
        if (s.prot_fail_high && x.protect_line_fail) return {1'b1, LPS_WIN_FAIL, 1'b0};
        if (s.maint_forced && k.forced_switch_request)
            return {1'b1, LPS_WIN_FORCE, k.target_protect};
        if (x.work_line_fail != x.protect_line_fail)
            return {1'b1, LPS_WIN_FAIL, x.work_line_fail};
        if (s.degrade_included && (x.work_line_degrade != x.protect_line_degrade))
            return {1'b1, LPS_WIN_DEGRADE, x.work_line_degrade};
        if (!k.manual_switch_request) return 5'h00;
        if (k.target_protect ? x.protect_line_fail : x.work_line_fail) return 5'h00;
        return {1'b1, LPS_WIN_MANUAL, k.target_protect};
    endfunction : expect_arb

    task automatic check(string name, logic [7:0] seen, logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", name, want, seen);
        end
    endtask : check

    task automatic step(lps_alarm_t x, lps_cmd_t k, lps_cfg_t s);
        @(posedge clk);
        want_alarm = x;
        want_cmd = k;
        want_cfg = s;
        @(negedge clk);
        @(negedge clk);
    endtask : step

    task automatic lock_run(logic [7:0] n, logic [5:0] hours);
        lps_cfg_t s;
        s = {4'h0, n, 6'h0A, hours};
        step(pf, '0, s);
        s.lockin_used = 1'b1;
        step(pf, '0, s);
        for (int i = 1; i <= n + 1; i++) begin
            step(i % 2 ? wf : pf, '0, s);
            check("select", sel, 8'(i % 2));
        end
        @(negedge clk);
        check("lockin", lock, 8'h01);
        step(n % 2 ? wf : pf, '0, s);
        check("select held", sel, 8'((n + 1) % 2));
        check("winner held", win, 8'(LPS_WIN_LOCK));
    endtask : lock_run

    task finish_test;
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end

    initial begin
        pf = '0;
        pf.protect_line_fail = 1'b1;
        wf = '0;
        wf.work_line_fail = 1'b1;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check("reset select", sel, 8'h00);
        check("reset winner", win, 8'(LPS_WIN_NONE));
        // random arbitration, lock-in unused
        for (int i = 0; i < 150; i++) begin
            lfsr = lfsr_next(lfsr);
            a = lfsr[4:0];
            a.redundant_unit_absent = lfsr[4] & lfsr[11];
            c = lfsr[7:5];
            g = {lfsr[8], lfsr[9], lfsr[10], 1'b0, 8'h04, 6'h0A, 6'h18};
            step(a, c, g);
            exp = expect_arb(a, c, g);
            if (exp[4]) begin
                last_sel = exp[0];
            end
            check("select", sel, 8'(last_sel));
            check("winner", win, 8'(exp[3:1]));
            check("lockin unused", lock, 8'h00);
        end
        // lock-in at default count, released by hold expiry
        lock_run(8'h04, 6'h01);
        @(posedge clk);
        want_tick = 1'b1;
        cnt = 0;
        while (lock === 1'b1 && cnt < 4000) begin
            @(negedge clk);
            cnt++;
        end
        @(posedge clk);
        want_tick = 1'b0;
        check("hold span", 8'(cnt > 3500 && cnt < 3700), 8'h01);
        // lowest count, released by a count edit, then by usage off
        lock_run(8'h01, 6'h01);
        step(pf, '0, {4'h1, 8'h02, 6'h0A, 6'h01});
        check("lockin edit", lock, 8'h00);
        lock_run(8'h01, 6'h01);
        step(pf, '0, {4'h0, 8'h01, 6'h0A, 6'h01});
        check("lockin release", lock, 8'h00);
        // one-minute watch window clears the count between switches
        g = {4'h1, 8'h01, 6'h01, 6'h01};
        step(pf, '0, g);
        step(wf, '0, g);
        @(posedge clk);
        want_tick = 1'b1;
        repeat (70) @(posedge clk);
        want_tick = 1'b0;
        step(pf, '0, g);
        check("window clear", lock, 8'h00);
        finish_test();
    end
endmodule : tb
